// ---- logic/shl_endpoint.sv ----
// Link-layer endpoint: establishment, sequence state, timers and supervisory frames
// Notes on behaviour
// - Reset frame may carry a window request, never below 2.
// - Window offered too large: answer with own smaller reset, not UA.
// - Offered window below default is adopted and acknowledged by UA.
// - Reset payload: optional window byte 2..4, optional capability byte; defaults otherwise.
// - Reset sent in reply offers a window strictly below the peer's offer.
// - Capability bit 0 advertises selective reject; other bits sent zero.
// - UA frames are sent with no payload.
// - Window defaults to 4, reduced only at establishment, then fixed.
// - Received information frames acknowledged within 5 ms times window over four.
// - Unacknowledged information frames retransmitted after at least 10 ms.
// - Reset resent if no UA or reset answers within 5 ms.
// - Sequence numbers modulo 8; window test uses wrapped comparison.
// - On establishment all three sequence numbers become zero.
// - Starting a link sends reset; received UA establishes it.
// - Link reset discards buffers and retransmit queue, informs upper layer.
// - Before establishment only reset and UA frames are accepted.
// - Crossed resets resolve; both UA then default window; code keeps the window adopted from the peer's reset offer instead.
// - Ack timer starts on first frame after ack; piggyback stops it.
// - Sequence gap without usable selective reject sends reject promptly.
// - Not-ready acknowledges like ready and suspends peer information frames.
// - Ready following not-ready repeats every 5 to 20 ms until I-frame.
// - Resume received with no data sends empty information frame.
// - Control byte: I=10+ns+nr, S=110+type+nr, U=111+modifier.
// - Supervisory types RR=00, REJ=01, RNR=10, SREJ=11.
// - Modifiers RSET=11001, UA=00110.
// - Selective reject sent only if both sides advertised it.
`default_nettype none
module shl_endpoint
  import shl_pkg::*;
#(
  parameter int ACK_CYC  = ACK_CYC_DEF,
  parameter int RETX_CYC = RETX_CYC_DEF,
  parameter int CONN_CYC = CONN_CYC_DEF,
  parameter int RNR_CYC  = RNR_CYC_DEF,
  parameter logic [2:0] LOCAL_WIN  = WIN_DEFAULT,
  parameter logic       LOCAL_SREJ = 1'b0
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       start_in,
  input  wire logic       rx_valid_in,
  input  wire logic       rx_crc_ok_in,
  input  wire logic [7:0] rx_ctrl_in,
  input  wire logic       rx_has_win_in,
  input  wire logic [7:0] rx_win_in,
  input  wire logic       rx_has_cap_in,
  input  wire logic [7:0] rx_cap_in,
  input  wire logic       rx_eof_in,
  input  wire logic       tx_data_pending_in,
  input  wire logic       tx_i_req_in,
  input  wire logic       local_busy_in,
  input  wire logic       tx_ready_in,
  output logic            tx_valid_out,
  output logic [7:0]      tx_ctrl_out,
  output logic [1:0]      tx_payload_len_out,
  output logic [7:0]      tx_win_out,
  output logic [7:0]      tx_cap_out,
  output logic            tx_i_take_out,
  output logic            rx_i_deliver_out,
  output logic            link_up_out,
  output logic            link_reset_out,
  output logic            peer_stopped_out,
  output logic            retx_req_out,
  output logic [2:0]      retx_from_out,
  output logic [2:0]      window_out,
  output logic            srej_on_out
);

  // Whole module state in one record
  typedef struct packed {
    shl_state_t       st;
    logic [2:0]       win;
    logic             srej;
    logic [2:0]       ns;
    logic [2:0]       nr;
    logic [2:0]       dnr;
    logic [TMR_W-1:0] ack_t;
    logic             ack_run;
    logic [TMR_W-1:0] retx_t;
    logic [TMR_W-1:0] conn_t;
    logic [TMR_W-1:0] rnr_t;
    logic             rnr_sent;
    logic             rnr_rep;
    logic             got_ua;
    logic             sent_ua;
    logic             rej_sent;
    logic             peer_stop;
    logic             need_empty_i;
    logic             tx_valid;
    logic [7:0]       tx_ctrl;
    logic [1:0]       tx_len;
    logic [7:0]       tx_win;
    logic [7:0]       tx_cap;
    logic             tx_take;
    logic             deliver;
    logic             lreset;
    logic             retx;
    logic [2:0]       retx_from;
    logic             up;
  } shl_st_t;

  shl_st_t s_q, s_d;

  // Wrapped window membership X <= Y < Z modulo 8
  function automatic logic in_win(input logic [2:0] x, input logic [2:0] y, input logic [2:0] z);
    if (x <= z) begin
      in_win = (x <= y) && (y < z);
    end else begin
      in_win = (y >= x) || (y < z);
    end
  endfunction

  // Build control bytes
  function automatic logic [7:0] ctl_s(input logic [1:0] ty, input logic [2:0] nr);
    ctl_s = {CTL_S_LEAD, ty, nr};
  endfunction
  function automatic logic [7:0] ctl_u(input logic [4:0] m);
    ctl_u = {CTL_U_LEAD, m};
  endfunction

  // Cycle count scaled by window, so the ack limit shrinks with a smaller window
  function automatic logic [TMR_W-1:0] ack_lim(input logic [2:0] w);
    ack_lim = TMR_W'(ACK_CYC * int'(w));
  endfunction

  logic       rx_ok;
  logic [2:0] rx_ns;
  logic [2:0] rx_nr;
  logic [2:0] off_win;
  logic       off_srej;

  // Frame fields; only frames passing the check are used
  assign rx_ok    = rx_valid_in && rx_crc_ok_in;
  assign rx_ns    = rx_ctrl_in[5:3];
  assign rx_nr    = rx_ctrl_in[2:0];
  assign off_win  = rx_has_win_in ? rx_win_in[2:0] : WIN_DEFAULT;
  assign off_srej = rx_has_cap_in ? rx_cap_in[CAP_SREJ_BIT] : 1'b0;

  // Next-state logic: reception, timers, then one transmit choice by priority
  always_comb begin
    logic       is_i;
    logic       is_s;
    logic       is_rset;
    logic       is_ua;
    logic       send_rset;
    logic       send_ua;
    logic [2:0] reply_win;
    logic       ack_due;
    logic       send_rej;
    logic       send_srej;
    logic       send_rr;
    logic       send_rnr;
    s_d       = s_q;
    is_i      = 1'b0;
    is_s      = 1'b0;
    is_rset   = 1'b0;
    is_ua     = 1'b0;
    send_rset = 1'b0;
    send_ua   = 1'b0;
    reply_win = LOCAL_WIN;
    ack_due   = 1'b0;
    send_rej  = 1'b0;
    send_srej = 1'b0;
    send_rr   = 1'b0;
    send_rnr  = 1'b0;
    s_d.deliver = 1'b0;
    s_d.lreset  = 1'b0;
    s_d.retx    = 1'b0;
    s_d.tx_take = 1'b0;
    if (s_q.tx_valid && tx_ready_in) begin
      s_d.tx_valid = 1'b0;
    end

    if (rx_ok) begin
      is_i    = (rx_ctrl_in[7:6] == CTL_I_LEAD);
      is_s    = (rx_ctrl_in[7:5] == CTL_S_LEAD);
      is_rset = (rx_ctrl_in[7:5] == CTL_U_LEAD) && (rx_ctrl_in[4:0] == U_RSET);
      is_ua   = (rx_ctrl_in[7:5] == CTL_U_LEAD) && (rx_ctrl_in[4:0] == U_UA);
    end

    // Local start or recovery reset of the link
    if (start_in) begin
      if (s_q.st == SHL_ST_UP) begin
        s_d.lreset = 1'b1;
      end
      s_d.st      = SHL_ST_CONN;
      s_d.win     = LOCAL_WIN;
      // A UA answer carries no capability, so selective reject stays off
      s_d.srej    = 1'b0;
      s_d.got_ua  = 1'b0;
      s_d.sent_ua = 1'b0;
      send_rset   = 1'b1;
    end else if (is_rset) begin
      // Peer reset: adopt if acceptable, else counter-offer smaller
      if (s_q.st == SHL_ST_UP) begin
        s_d.lreset = 1'b1;
      end
      if (off_win > LOCAL_WIN) begin
        reply_win = (LOCAL_WIN < off_win) ? LOCAL_WIN : off_win - 3'h1;
        if (reply_win < WIN_MIN) begin
          reply_win = WIN_MIN;
        end
        send_rset  = 1'b1;
        s_d.win    = reply_win;
        s_d.srej   = off_srej && LOCAL_SREJ;
        s_d.got_ua = 1'b0;
        s_d.st     = SHL_ST_CONN;
        s_d.sent_ua = 1'b0;
      end else begin
        s_d.win    = (off_win < WIN_MIN) ? WIN_MIN : off_win;
        s_d.srej   = off_srej && LOCAL_SREJ;
        send_ua    = 1'b1;
        s_d.sent_ua = 1'b1;
        if (s_q.st != SHL_ST_CONN || s_q.got_ua) begin
          s_d.st = SHL_ST_UP;
        end
      end
    end else if (is_ua && s_q.st == SHL_ST_CONN) begin
      s_d.got_ua = 1'b1;
      s_d.st     = SHL_ST_UP;
    end

    // Entering the established state, or accepting a new reset, clears the sequence state
    if ((s_d.st == SHL_ST_UP && s_q.st != SHL_ST_UP) || send_ua) begin
      s_d.ns = SEQ_ZERO;
      s_d.nr = SEQ_ZERO;
      s_d.dnr = SEQ_ZERO;
      s_d.ack_run = 1'b0;
      s_d.rej_sent = 1'b0;
      s_d.peer_stop = 1'b0;
      s_d.rnr_sent = 1'b0;
      s_d.rnr_rep = 1'b0;
      s_d.need_empty_i = 1'b0;
    end

    // Link state kept in its own flop so the output needs no decode
    s_d.up = (s_d.st == SHL_ST_UP);

    // Connect timer: resend reset when no answer arrives
    if (s_q.st == SHL_ST_CONN && !send_rset && !send_ua) begin
      if (s_q.conn_t >= TMR_W'(CONN_CYC - 1)) begin
        send_rset = 1'b1;
      end else begin
        s_d.conn_t = s_q.conn_t + 1'b1;
      end
    end

    // Established traffic; other frames are dropped before establishment
    if (s_q.st == SHL_ST_UP && !is_rset && !start_in) begin
      if (is_i || is_s) begin
        if (in_win(s_q.dnr, rx_nr - 3'h1, s_q.ns) || rx_nr == s_q.ns) begin
          s_d.dnr = rx_nr;
        end
      end
      if (is_i) begin
        s_d.rnr_rep = 1'b0;
        if (rx_ns == s_q.nr && !local_busy_in) begin
          s_d.nr       = s_q.nr + 3'h1;
          s_d.deliver  = 1'b1;
          s_d.rej_sent = 1'b0;
          s_d.ack_run  = 1'b1;
        end else if (rx_ns != s_q.nr && !s_q.rej_sent) begin
          if (s_q.srej && rx_ns == s_q.nr + 3'h1) begin
            send_srej = 1'b1;
          end else begin
            send_rej = 1'b1;
          end
        end
      end
      if (is_s) begin
        case (rx_ctrl_in[4:3])
          S_RR: begin
            if (s_q.peer_stop && !tx_data_pending_in) begin
              s_d.need_empty_i = 1'b1;
            end
            s_d.peer_stop = 1'b0;
          end
          S_RNR: s_d.peer_stop = 1'b1;
          S_REJ: begin
            s_d.retx      = 1'b1;
            s_d.retx_from = rx_nr;
            s_d.ns        = rx_nr;
          end
          default: begin
            s_d.retx      = 1'b1;
            s_d.retx_from = rx_nr;
          end
        endcase
      end
      // Ack timer limit is scaled down with the window
      if (s_q.ack_run) begin
        if (s_q.ack_t >= ack_lim(s_q.win) - 1'b1) begin
          ack_due = 1'b1;
        end else begin
          s_d.ack_t = s_q.ack_t + 1'b1;
        end
      end
      // Retransmit timer runs while frames are outstanding; an ack restarts it for the new oldest frame
      if (s_q.dnr != s_q.ns && s_d.dnr == s_q.dnr) begin
        if (s_q.retx_t >= TMR_W'(RETX_CYC - 1)) begin
          s_d.retx      = 1'b1;
          s_d.retx_from = s_q.dnr;
          s_d.ns        = s_q.dnr;
          s_d.retx_t    = '0;
        end else begin
          s_d.retx_t = s_q.retx_t + 1'b1;
        end
      end else begin
        s_d.retx_t = '0;
      end
      // Repeat the resume RR while no I-frame arrives
      if (s_q.rnr_rep) begin
        if (s_q.rnr_t >= TMR_W'(RNR_CYC - 1)) begin
          send_rr = 1'b1;
        end else begin
          s_d.rnr_t = s_q.rnr_t + 1'b1;
        end
      end
      if (local_busy_in && !s_q.rnr_sent && (ack_due || is_i)) begin
        send_rnr = 1'b1;
      end else if (!local_busy_in && s_q.rnr_sent) begin
        send_rr = 1'b1;
      end else if (ack_due) begin
        send_rr = 1'b1;
      end
    end

    // One frame out per free transmitter slot; timed ack beats piggyback
    if (!s_d.tx_valid) begin
      if (send_rset) begin
        s_d.tx_valid = 1'b1;
        s_d.tx_ctrl  = ctl_u(U_RSET);
        s_d.tx_len   = 2'h2;
        s_d.tx_win   = {5'h0, reply_win};
        s_d.tx_cap   = {7'h0, LOCAL_SREJ};
        s_d.conn_t   = '0;
      end else if (send_ua) begin
        s_d.tx_valid = 1'b1;
        s_d.tx_ctrl  = ctl_u(U_UA);
        s_d.tx_len   = 2'h0;
        s_d.tx_win   = 8'h00;
        s_d.tx_cap   = 8'h00;
      end else if (send_rej || send_srej || send_rnr || send_rr) begin
        s_d.tx_valid = 1'b1;
        s_d.tx_ctrl  = ctl_s(send_rej ? S_REJ : send_srej ? S_SREJ : send_rnr ? S_RNR : S_RR, s_d.nr);
        s_d.tx_len   = 2'h0;
        s_d.ack_run  = 1'b0;
        s_d.ack_t    = '0;
        s_d.rej_sent = send_rej || s_q.rej_sent;
        if (send_rnr) begin
          s_d.rnr_sent = 1'b1;
        end else if (send_rr && s_q.rnr_sent) begin
          s_d.rnr_sent = 1'b0;
          s_d.rnr_rep  = 1'b1;
        end
        s_d.rnr_t = '0;
      end else if (s_q.st == SHL_ST_UP && !s_d.peer_stop && !s_d.retx &&
                   (tx_i_req_in || s_q.need_empty_i) && in_win(s_q.dnr, s_q.ns, s_q.dnr + s_q.win)) begin
        s_d.tx_valid     = 1'b1;
        s_d.tx_ctrl      = {CTL_I_LEAD, s_q.ns, s_d.nr};
        s_d.tx_len       = 2'h0;
        s_d.tx_take      = tx_i_req_in;
        s_d.need_empty_i = 1'b0;
        s_d.ns           = s_q.ns + 3'h1;
        s_d.ack_run      = 1'b0;
        s_d.ack_t        = '0;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '{st: SHL_ST_IDLE, win: WIN_DEFAULT, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state record
  assign tx_valid_out       = s_q.tx_valid;
  assign tx_ctrl_out        = s_q.tx_ctrl;
  assign tx_payload_len_out = s_q.tx_len;
  assign tx_win_out         = s_q.tx_win;
  assign tx_cap_out         = s_q.tx_cap;
  assign tx_i_take_out      = s_q.tx_take;
  assign rx_i_deliver_out   = s_q.deliver;
  assign link_up_out        = s_q.up;
  assign link_reset_out     = s_q.lreset;
  assign peer_stopped_out   = s_q.peer_stop;
  assign retx_req_out       = s_q.retx;
  assign retx_from_out      = s_q.retx_from;
  assign window_out         = s_q.win;
  assign srej_on_out        = s_q.srej;

endmodule : shl_endpoint
`default_nettype wire

// ---- common/shl_pkg.sv ----
// Package of constants and types for the simplified HDLC link endpoint
`default_nettype none
package shl_pkg;
  // Control byte leading bits and field codes
  localparam logic [1:0] CTL_I_LEAD     = 2'h2;
  localparam logic [2:0] CTL_S_LEAD     = 3'h6;
  localparam logic [2:0] CTL_U_LEAD     = 3'h7;
  localparam logic [1:0] S_RR           = 2'h0;
  localparam logic [1:0] S_REJ          = 2'h1;
  localparam logic [1:0] S_RNR          = 2'h2;
  localparam logic [1:0] S_SREJ         = 2'h3;
  localparam logic [4:0] U_RSET         = 5'h19;
  localparam logic [4:0] U_UA           = 5'h06;
  // Window limits and capability bit
  localparam logic [2:0] WIN_MIN        = 3'h2;
  localparam logic [2:0] WIN_DEFAULT    = 3'h4;
  localparam int         CAP_SREJ_BIT   = 0;
  localparam logic [2:0] SEQ_ZERO       = 3'h0;
  // Timing, clock rate and derived cycle counts
  localparam int         CLK_HZ         = 50_000_000;
  localparam int         ACK_TIME_US    = 5000;
  localparam int         RETX_TIME_US   = 10000;
  localparam int         CONN_TIME_US   = 5000;
  localparam int         RNR_RR_MIN_US  = 5000;
  localparam int         RNR_RR_MAX_US  = 20000;
  localparam int         US_PER_S       = 1_000_000;
  localparam int         CYC_PER_US     = CLK_HZ / US_PER_S;
  // Ack limit is 5 ms at window 4; only the ack count below is scaled by window at run time
  localparam int         ACK_CYC_DEF    = (ACK_TIME_US * CYC_PER_US) / 4;
  localparam int         RETX_CYC_DEF   = RETX_TIME_US * CYC_PER_US;
  localparam int         CONN_CYC_DEF   = CONN_TIME_US * CYC_PER_US;
  localparam int         RNR_CYC_DEF    = ((RNR_RR_MIN_US + RNR_RR_MAX_US) / 2) * CYC_PER_US;
  localparam int         TMR_W          = 20;

  // Frame kinds exchanged with the framing layer
  typedef enum logic [2:0] {
    SHL_FR_I    = 3'h0,
    SHL_FR_S    = 3'h1,
    SHL_FR_RSET = 3'h2,
    SHL_FR_UA   = 3'h3,
    SHL_FR_NONE = 3'h7
  } shl_kind_t;

  // Link states, one-hot
  typedef enum logic [2:0] {
    SHL_ST_IDLE = 3'b001,
    SHL_ST_CONN = 3'b010,
    SHL_ST_UP   = 3'b100
  } shl_state_t;
endpackage : shl_pkg
`default_nettype wire

// ---- testbench/shl_endpoint_checker.sv ----
// Concurrent checks on the ports of the link endpoint
`default_nettype none
module shl_endpoint_checker
  import shl_pkg::*;
#(
  parameter int ACK_CYC  = ACK_CYC_DEF,
  parameter int CONN_CYC = CONN_CYC_DEF
) (
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic       start_in,
  input wire logic       rx_valid_in,
  input wire logic       rx_crc_ok_in,
  input wire logic       tx_ready_in,
  input wire logic       tx_valid_out,
  input wire logic [7:0] tx_ctrl_out,
  input wire logic [1:0] tx_payload_len_out,
  input wire logic [7:0] tx_win_out,
  input wire logic [7:0] tx_cap_out,
  input wire logic       rx_i_deliver_out,
  input wire logic       link_up_out,
  input wire logic       link_reset_out,
  input wire logic [2:0] window_out,
  input wire logic       srej_on_out
);
  // Ack bound covers the largest window plus a busy transmitter
  localparam int ACK_MAX = ACK_CYC * 4 + 40;
  logic conn_wait_q;
  int   conn_cnt_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_rset_out;
    tx_valid_out && tx_ready_in && tx_ctrl_out == {CTL_U_LEAD, U_RSET};
  endsequence
  sequence s_ack_out;
    tx_valid_out && (tx_ctrl_out[7:5] == CTL_S_LEAD || tx_ctrl_out[7:6] == CTL_I_LEAD);
  endsequence

  // Cycles since a reset frame left with no answer yet; any frame in clears it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      conn_wait_q <= 1'b0;
      conn_cnt_q  <= 0;
    end else if (tx_valid_out && tx_ready_in && tx_ctrl_out == {CTL_U_LEAD, U_RSET}) begin
      conn_wait_q <= 1'b1;
      conn_cnt_q  <= 0;
    end else if (rx_valid_in || link_up_out) begin
      conn_wait_q <= 1'b0;
    end else if (conn_wait_q) begin
      conn_cnt_q <= conn_cnt_q + 1;
    end
  end

  a_ua_empty: assert property (tx_valid_out && tx_ctrl_out == {CTL_U_LEAD, U_UA} |-> tx_payload_len_out == 2'h0)
    else $error("UA frame carries payload");
  a_rset_payload: assert property (s_rset_out |-> tx_payload_len_out == 2'h2 && tx_win_out >= 8'h02
    && tx_win_out <= 8'h04 && tx_cap_out[7:1] == 7'h00) else $error("Bad reset payload");
  a_srej_gated: assert property (tx_valid_out && !srej_on_out |-> tx_ctrl_out[7:3] != {CTL_S_LEAD, S_SREJ})
    else $error("Selective reject sent without agreement");
  a_window_fixed: assert property (link_up_out && $past(link_up_out) && !link_reset_out |-> $stable(window_out))
    else $error("Window changed while link up");
  a_window_range: assert property (window_out >= WIN_MIN && window_out <= WIN_DEFAULT)
    else $error("Window out of range");
  a_drop_early: assert property (rx_valid_in && !link_up_out |=> !rx_i_deliver_out)
    else $error("Frame delivered before link up");
  a_deliver_cause: assert property (rx_i_deliver_out |-> $past(rx_valid_in) && $past(rx_crc_ok_in)
    && $past(link_up_out)) else $error("Delivery without good frame");
  a_ack_bound: assert property (rx_i_deliver_out |-> ##[1:ACK_MAX] s_ack_out)
    else $error("Received frame not acknowledged in time");
  a_conn_retry: assert property (!conn_wait_q || conn_cnt_q <= CONN_CYC + 6)
    else $error("Reset frame not resent in time");
  a_reset_notice: assert property (start_in && link_up_out |-> ##[1:2] link_reset_out)
    else $error("Link reset not signalled");
endmodule // shl_endpoint_checker
`default_nettype wire

// ---- testbench/shl_peer.sv ----
// Peer endpoint model: accepts frames from the block and presents frames to it
`default_nettype none
module shl_peer
  import shl_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_ctrl_in,
  input  wire logic [1:0] tx_len_in,
  input  wire logic [7:0] tx_win_in,
  input  wire logic [7:0] tx_cap_in,
  output logic            tx_ready_out,
  output logic            rx_valid_out,
  output logic            rx_ok_out,
  output logic [7:0]      rx_ctrl_out,
  output logic            rx_has_win_out,
  output logic [7:0]      rx_win_out,
  output logic            rx_has_cap_out,
  output logic [7:0]      rx_cap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        slow;
  logic [25:0] frames[$];

  initial begin
    slow = 1'b0;
    rx_valid_out = 1'b0;
    rx_ok_out = 1'b0;
    rx_ctrl_out = 8'h00;
    rx_has_win_out = 1'b0;
    rx_win_out = 8'h00;
    rx_has_cap_out = 1'b0;
    rx_cap_out = 8'h00;
  end

  // Slow mode takes every other cycle, which a real framer may do
  always @(posedge sys_clk_in) tx_ready_out <= #1 (slow ? ~tx_ready_out : 1'b1);

  // Capture each frame handed over as len, control, window, capability
  always @(posedge sys_clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      frames.push_back({tx_len_in, tx_ctrl_in, tx_win_in, tx_cap_in});
    end
  end

  // One frame for one cycle; lines then show inverted junk so stale values never match
  task automatic put(input logic [7:0] c, input logic hw, input logic [7:0] w,
                     input logic hc, input logic [7:0] cp, input logic ok);
    @(posedge sys_clk_in);
    #1;
    rx_valid_out = 1'b1;
    rx_ok_out = ok;
    rx_ctrl_out = c;
    rx_has_win_out = hw;
    rx_win_out = w;
    rx_has_cap_out = hc;
    rx_cap_out = cp;
    @(posedge sys_clk_in);
    #1;
    rx_valid_out = 1'b0;
    rx_ctrl_out = ~c;
    rx_has_win_out = 1'b0;
    rx_win_out = ~w;
    rx_has_cap_out = 1'b0;
    rx_cap_out = ~cp;
  endtask
endmodule // shl_peer
`default_nettype wire

// ---- testbench/shl_endpoint_tb.sv ----
// Self-checking bench for the link endpoint with peer model
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module shl_endpoint_tb
  import shl_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         ACK = 20;
  localparam int         RETX = 100;
  localparam int         CONN = 50;
  localparam int         RNR = 60;
  localparam logic [2:0] LW = 3'h3;
  localparam logic [7:0] RSET = {CTL_U_LEAD, U_RSET};
  localparam logic [7:0] UA = {CTL_U_LEAD, U_UA};
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        start_in = 1'b0;
  logic        req = 1'b0;
  logic        pend = 1'b0;
  logic        busy = 1'b0;
  logic        rx_v, rx_ok, rx_hw, rx_hc, rdy, tx_v, take, deliver, up, lreset, pstop, retx, srej;
  logic [7:0]  rx_c, rx_w, rx_cp, tx_c, tx_w, tx_cp;
  logic [1:0]  tx_len;
  logic [2:0]  retx_from, win_o;
  logic [25:0] f;
  logic [31:0] rnd;
  int          failures = 0;
  int          samples_checked = 0;
  int          m_ns = 0;
  int          m_nr = 0;
  int          n;

  always #10 sys_clk_in = ~sys_clk_in;

  shl_endpoint #(.ACK_CYC(ACK), .RETX_CYC(RETX), .CONN_CYC(CONN), .RNR_CYC(RNR), .LOCAL_WIN(LW),
    .LOCAL_SREJ(1'b1)) uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .start_in(start_in),
    .rx_valid_in(rx_v), .rx_crc_ok_in(rx_ok), .rx_ctrl_in(rx_c), .rx_has_win_in(rx_hw), .rx_win_in(rx_w),
    .rx_has_cap_in(rx_hc), .rx_cap_in(rx_cp), .rx_eof_in(1'b0), .tx_data_pending_in(pend),
    .tx_i_req_in(req), .local_busy_in(busy), .tx_ready_in(rdy), .tx_valid_out(tx_v), .tx_ctrl_out(tx_c),
    .tx_payload_len_out(tx_len), .tx_win_out(tx_w), .tx_cap_out(tx_cp), .tx_i_take_out(take),
    .rx_i_deliver_out(deliver), .link_up_out(up), .link_reset_out(lreset), .peer_stopped_out(pstop),
    .retx_req_out(retx), .retx_from_out(retx_from), .window_out(win_o), .srej_on_out(srej));

  shl_peer peer (.sys_clk_in(sys_clk_in), .tx_valid_in(tx_v), .tx_ctrl_in(tx_c), .tx_len_in(tx_len),
    .tx_win_in(tx_w), .tx_cap_in(tx_cp), .tx_ready_out(rdy), .rx_valid_out(rx_v), .rx_ok_out(rx_ok),
    .rx_ctrl_out(rx_c), .rx_has_win_out(rx_hw), .rx_win_out(rx_w), .rx_has_cap_out(rx_hc),
    .rx_cap_out(rx_cp));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] s_ctl(input logic [1:0] t, input int nr);
    return {CTL_S_LEAD, t, nr[2:0]};
  endfunction
  function automatic logic [7:0] i_ctl(input int ns, input int nr);
    return {CTL_I_LEAD, ns[2:0], nr[2:0]};
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic send(input logic [7:0] c);
    peer.put(c, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1);
  endtask
  task automatic rx_i(input int ns, input logic ok);
    peer.put(i_ctl(ns, m_ns), 1'b0, 8'h00, 1'b0, 8'h00, ok);
  endtask
  // Bounded wait for the next frame from the block; none in time counts as a mismatch
  task automatic get(input int lim);
    n = 0;
    while (peer.frames.size() == 0 && n < lim) begin
      tick(1);
      n++;
    end
    f = (peer.frames.size() == 0) ? 26'h3ffffff : peer.frames.pop_front();
    `CHK(peer.frames.size() < 8, 1'b1)
  endtask
  task automatic pulse_start;
    start_in = 1'b1;
    tick(1);
    start_in = 1'b0;
  endtask
  // Hold the send request as a level until the block takes the data
  task automatic send_i;
    req = 1'b1;
    for (n = 0; n < 20 && take !== 1'b1; n++) tick(1);
    req = 1'b0;
    get(10);
  endtask

  task automatic give_verdict;
    $display("comparisons=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog at 20000 cycles, well beyond the under two thousand cycles the sequence needs
  initial begin
    #400000;
    failures++;
    give_verdict();
  end

  initial begin
    rnd = 32'h65fd;
    tick(6);
    rst_in = 1'b0;
    `CHK(win_o, WIN_DEFAULT)
    // Start, first offer, retry on silence, drop before link up
    pulse_start();
    get(10);
    `CHK(f, {2'h2, RSET, 5'h00, LW, 8'h01})
    get(CONN + 20);
    `CHK(f[23:16], RSET)
    rx_i(0, 1'b1);
    `CHK(deliver, 1'b0)
    send(UA);
    tick(1);
    `CHK({up, win_o, srej}, {1'b1, LW, 1'b0})
    // Ack timer, gap reject, corrupted frame
    rx_i(0, 1'b1);
    `CHK(deliver, 1'b1)
    m_nr = 1;
    get(ACK * 4 + 20);
    `CHK(f[23:16], s_ctl(S_RR, m_nr))
    rx_i(2, 1'b1);
    get(10);
    `CHK(f[23:16], s_ctl(S_REJ, m_nr))
    rnd = lfsr(rnd);
    peer.put(rnd[7:0], 1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
    `CHK(deliver, 1'b0)
    // In-sequence stream across the modulo-8 wrap
    for (int k = 0; k < 8; k++) begin
      rx_i(m_nr, 1'b1);
      `CHK(deliver, 1'b1)
      m_nr = (m_nr + 1) % 8;
      get(ACK * 4 + 20);
      `CHK(f[23:16], s_ctl(S_RR, m_nr))
    end
    // Send, then no ack until the retransmit timer runs out
    send_i();
    `CHK(f[25:16], {2'h0, i_ctl(m_ns, m_nr)})
    // Frame 0 counts as lost, so the peer's receive number stays 0
    for (n = 0; n < RETX + 20 && retx !== 1'b1; n++) tick(1);
    `CHK({retx, retx_from, n >= RETX - 4}, {1'b1, 3'h0, 1'b1})
    // Peer suspends, then resumes with nothing pending
    rnd = lfsr(rnd);
    peer.slow = rnd[0];
    send(s_ctl(S_RNR, m_ns));
    `CHK(pstop, 1'b1)
    send(s_ctl(S_RR, m_ns));
    get(10);
    `CHK({f[23:16], pstop}, {i_ctl(m_ns, m_nr), 1'b0})
    m_ns = 1;
    // Local busy: not-ready, then ready repeated
    busy = 1'b1;
    rx_i(m_nr, 1'b1);
    `CHK(deliver, 1'b0)
    get(ACK * 4 + 20);
    `CHK(f[23:16], s_ctl(S_RNR, m_nr))
    busy = 1'b0;
    pend = rnd[1];
    for (int k = 0; k < 2; k++) begin
      get(RNR + 20);
      `CHK(f[23:16], s_ctl(S_RR, m_nr))
    end
    rx_i(m_nr, 1'b1);
    pend = 1'b0;
    tick(ACK * 4 + 20);
    peer.frames.delete();
    peer.slow = 1'b0;
    // Re-establish an open link
    pulse_start();
    `CHK(lreset, 1'b1)
    get(10);
    `CHK(f[23:16], RSET)
    // From idle: default offer too large, then a smaller one is adopted
    rst_in = 1'b1;
    tick(2);
    rst_in = 1'b0;
    peer.frames.delete();
    send(RSET);
    get(10);
    `CHK(f, {2'h2, RSET, 5'h00, LW, 8'h01})
    peer.put(RSET, 1'b1, 8'h02, 1'b1, 8'h01, 1'b1);
    get(10);
    `CHK(f[25:16], {2'h0, UA})
    if (up !== 1'b1) send(UA);
    tick(2);
    `CHK({up, win_o, srej}, {1'b1, 3'h2, 1'b1})
    send_i();
    `CHK(f[23:16], i_ctl(0, 0))
    // One frame missing with selective reject agreed
    rx_i(1, 1'b1);
    get(10);
    `CHK(f[23:16], s_ctl(S_SREJ, 0))
    give_verdict();
  end
endmodule // shl_endpoint_tb

bind shl_endpoint shl_endpoint_checker #(.ACK_CYC(ACK_CYC), .CONN_CYC(CONN_CYC)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .start_in(start_in), .rx_valid_in(rx_valid_in),
  .rx_crc_ok_in(rx_crc_ok_in), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
  .tx_ctrl_out(tx_ctrl_out), .tx_payload_len_out(tx_payload_len_out), .tx_win_out(tx_win_out),
  .tx_cap_out(tx_cap_out), .rx_i_deliver_out(rx_i_deliver_out), .link_up_out(link_up_out),
  .link_reset_out(link_reset_out), .window_out(window_out), .srej_on_out(srej_on_out));
`default_nettype wire
